// ==== shared/bus_space_pkg.sv ====
// Package for the external bus space configuration block.
// Holds register indices, field positions, reset values and the config carrier.
package bus_space_pkg;

    localparam int NUM_SPACES = 4;
    localparam int REG_WIDTH = 16;

    // Printed offsets are not all word multiples, so each is a register index.
    localparam logic [31:0] BUS_CONTROL_ONE_PRINTED = 32'hffff_8620;
    localparam logic [31:0] BUS_CONTROL_TWO_PRINTED = 32'hffff_8622;
    localparam logic [31:0] SPACE_CACHE_ENABLE_PRINTED = 32'hffff_8740;
    localparam logic [31:0] BLOCK_BASE_PRINTED = 32'hffff_8620;

    // Index relative to the block base; byte address on APB is four times it.
    localparam logic [9:0] IDX_BUS_CONTROL_ONE =
        10'(BUS_CONTROL_ONE_PRINTED - BLOCK_BASE_PRINTED);
    localparam logic [9:0] IDX_BUS_CONTROL_TWO =
        10'(BUS_CONTROL_TWO_PRINTED - BLOCK_BASE_PRINTED);
    localparam logic [9:0] IDX_SPACE_CACHE_ENABLE =
        10'(SPACE_CACHE_ENABLE_PRINTED - BLOCK_BASE_PRINTED);

    // Field positions.
    localparam int POS_DRAM_CACHEABLE = 4;
    localparam int POS_SPACE_CACHEABLE = 0;
    localparam int POS_MUXED_IO = 8;
    localparam int POS_WIDTH16 = 0;
    localparam int POS_IDLE_COUNT = 8;
    localparam int IDLE_COUNT_BITS = 2;
    localparam int POS_BACKTOBACK = 4;
    localparam int POS_STRETCH = 0;

    // Writable masks; everything outside reads as zero and ignores writes.
    localparam logic [15:0] MASK_BUS_CONTROL_ONE = 16'h010f;
    localparam logic [15:0] MASK_BUS_CONTROL_TWO = 16'hffff;
    localparam logic [15:0] MASK_SPACE_CACHE_ENABLE = 16'h001f;

    // Reset values.
    localparam logic [15:0] RST_BUS_CONTROL_ONE = 16'h000f;
    localparam logic [15:0] RST_BUS_CONTROL_TWO = 16'hffff;
    localparam logic [15:0] RST_SPACE_CACHE_ENABLE = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } apb_state_t;

    typedef enum logic [1:0] {
        SEL_ONE,
        SEL_TWO,
        SEL_CACHE,
        SEL_NONE
    } reg_sel_t;

    // Settings handed to the bus timing logic.
    typedef struct packed {
        logic dram_space_cacheable;
        logic [NUM_SPACES-1:0] space_cacheable;
        logic space3_muxed_io;
        logic [NUM_SPACES-1:0] space_width16;
        logic [NUM_SPACES-1:0][IDLE_COUNT_BITS-1:0] space_idle_count;
        logic [NUM_SPACES-1:0] space_backtoback_idle;
        logic [NUM_SPACES-1:0] space_select_stretch;
    } bus_space_cfg_t;

endpackage : bus_space_pkg

// ==== rtl/pin_sync2.sv ====
// Two-flop synchroniser for a bundle of static mode pins.
// Assumes the pins are quasi-static straps sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            pin_out <= '0;
        end else begin
            meta_q <= pin_in;
            pin_out <= meta_q;
        end
    end

endmodule : pin_sync2
`default_nettype wire

// ==== rtl/bus_space_config.sv ====
// External bus space configuration registers behind an APB slave.
// Assumes an APB master on clk and asynchronous mode pins for space 0 width.
// The mode pins are board straps that may move at any time, so they pass two flops first.
// Lanes 2 and 3 of pstrb are ignored because every register is sixteen bits wide.
`timescale 1ns/1ps
`default_nettype none
module bus_space_config
    import bus_space_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rom_enabled_pin,
    input wire logic mode_width16_pin,
    output bus_space_cfg_t cfg
);

    localparam int SYNC_WIDTH = 2;
    // Registers sit on whole 32-bit words, so an address with nonzero low bits maps to no register.
    localparam int WORD_SHIFT = 2;

    logic [15:0] bus_one_q;
    logic [15:0] bus_two_q;
    logic [15:0] cache_q;
    apb_state_t state_q;
    logic [SYNC_WIDTH-1:0] pins_sync;
    logic rom_enabled;
    logic mode_width16;
    reg_sel_t sel;
    logic wr_fire;
    logic [15:0] wr_mask;
    bus_space_cfg_t cfg_d;

    // Decodes a byte address into a register; used for both reads and writes.
    function automatic reg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] idx;
        idx = addr >> WORD_SHIFT;
        if (addr[WORD_SHIFT-1:0] != '0) begin
            decode = SEL_NONE;
        end else if (idx == ADDR_WIDTH'(IDX_BUS_CONTROL_ONE)) begin
            decode = SEL_ONE;
        end else if (idx == ADDR_WIDTH'(IDX_BUS_CONTROL_TWO)) begin
            decode = SEL_TWO;
        end else if (idx == ADDR_WIDTH'(IDX_SPACE_CACHE_ENABLE)) begin
            decode = SEL_CACHE;
        end else begin
            decode = SEL_NONE;
        end
    endfunction : decode

    // Merges a write through the selected byte lanes and the writable mask.
    // Reserved bits are forced to zero here, so no write can ever set them.
    function automatic logic [15:0] merge_write(
        input logic [15:0] old_value,
        input logic [15:0] new_value,
        input logic [15:0] lanes,
        input logic [15:0] writable
    );
        merge_write = ((old_value & ~lanes) | (new_value & lanes)) & writable;
    endfunction : merge_write

    // Shapes the read word: the upper half and every reserved bit read as zero.
    function automatic logic [31:0] read_word(
        input reg_sel_t which,
        input logic [15:0] one_value,
        input logic [15:0] two_value,
        input logic [15:0] cache_value
    );
        case (which)
            SEL_ONE: read_word = {16'h0000, one_value & MASK_BUS_CONTROL_ONE};
            SEL_TWO: read_word = {16'h0000, two_value & MASK_BUS_CONTROL_TWO};
            SEL_CACHE: read_word = {16'h0000, cache_value & MASK_SPACE_CACHE_ENABLE};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    pin_sync2 #(
        .WIDTH(SYNC_WIDTH)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({rom_enabled_pin, mode_width16_pin}),
        .pin_out(pins_sync)
    );

    assign rom_enabled = pins_sync[1];
    assign mode_width16 = pins_sync[0];
    assign sel = decode(paddr);
    // A write lands only on the edge where the master sees pready high.
    assign wr_fire = psel && penable && pwrite && pready && (sel != SEL_NONE);
    assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // One wait state: pready rises in the second access cycle, from a flop.
    // Mapped or not, every access gets that same single wait, so a bad address never hangs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            pready <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (psel && penable) begin
                        state_q <= ST_RESP;
                        pready <= 1'b1;
                    end
                end
                ST_RESP: begin
                    state_q <= ST_IDLE;
                    pready <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // The error flag rides with pready for an address that maps to no register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (state_q == ST_IDLE && psel && penable) begin
            pslverr <= (sel == SEL_NONE);
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Read data is loaded together with pready and cleared afterwards.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (state_q == ST_IDLE && psel && penable && !pwrite) begin
            prdata <= read_word(sel, bus_one_q, bus_two_q, cache_q);
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // First bus control register: multiplex enable and the four width bits.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_one_q <= RST_BUS_CONTROL_ONE;
        end else if (wr_fire && sel == SEL_ONE) begin
            // Reserved bits stay zero whatever is written.
            bus_one_q <= merge_write(bus_one_q, pwdata[15:0], wr_mask,
                MASK_BUS_CONTROL_ONE);
        end
    end

    // Second bus control register: idle counts, back-to-back idles and select stretch.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_two_q <= RST_BUS_CONTROL_TWO;
        end else if (wr_fire && sel == SEL_TWO) begin
            bus_two_q <= merge_write(bus_two_q, pwdata[15:0], wr_mask,
                MASK_BUS_CONTROL_TWO);
        end
    end

    // Cache enables; the undefined upper bits are held at zero for a stable read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cache_q <= RST_SPACE_CACHE_ENABLE;
        end else if (wr_fire && sel == SEL_CACHE) begin
            cache_q <= merge_write(cache_q, pwdata[15:0], wr_mask,
                MASK_SPACE_CACHE_ENABLE);
        end
    end

    // Next settings, gathered from the registers and the synchronised mode pins.
    always_comb begin
        cfg_d = '0;
        cfg_d.dram_space_cacheable = cache_q[POS_DRAM_CACHEABLE];
        cfg_d.space3_muxed_io = bus_one_q[POS_MUXED_IO];
        for (int i = 0; i < NUM_SPACES; i++) begin
            cfg_d.space_cacheable[i] = cache_q[POS_SPACE_CACHEABLE + i];
            cfg_d.space_idle_count[i] =
                bus_two_q[POS_IDLE_COUNT + IDLE_COUNT_BITS*i +: IDLE_COUNT_BITS];
            cfg_d.space_backtoback_idle[i] = bus_two_q[POS_BACKTOBACK + i];
            cfg_d.space_select_stretch[i] = bus_two_q[POS_STRETCH + i];
            cfg_d.space_width16[i] = bus_one_q[POS_WIDTH16 + i];
        end
        // Without on-chip ROM the board strap fixes the space 0 width, so software
        // cannot change the width of the space that the device boots from.
        if (!rom_enabled) begin
            cfg_d.space_width16[0] = mode_width16;
        end
    end

    // The settings are re-registered so the timing logic sees flop outputs.
    // A change reaches the timing logic one clock after the register write, so a
    // bus cycle already under way must latch what it needs when it starts.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_d;
        end
    end

endmodule : bus_space_config
`default_nettype wire

// ==== sim/bus_space_config_checker.sv ====
// Checker for the bus space configuration block.
// Sees only the top module's ports and is bound into every instance.
`timescale 1ns/1ps
`default_nettype none
module bus_space_config_checker
    import bus_space_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rom_enabled_pin,
    input wire logic mode_width16_pin,
    input wire bus_space_cfg_t cfg
);
    logic done, w1, w2, wc;
    assign done = psel && penable && pready && pwrite && !pslverr;
    assign w1 = done && paddr == ADDR_WIDTH'(12'h000);
    assign w2 = done && paddr == ADDR_WIDTH'(12'h008);
    assign wc = done && paddr == ADDR_WIDTH'(12'h480);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Settings reach cfg one edge after the register itself, hence two edges after the write.
    AST_CACHE: assert property (wc && pstrb[0]
        |-> ##2 {cfg.dram_space_cacheable, cfg.space_cacheable} == $past(pwdata[4:0], 2))
        else $error("cache enables wrong");
    AST_MUX: assert property (w1 && pstrb[1]
        |=> ##1 cfg.space3_muxed_io == $past(pwdata[8], 2)) else $error("mux wrong");
    AST_WIDTH: assert property (w1 && pstrb[0]
        |-> ##2 cfg.space_width16[3:1] == $past(pwdata[3:1], 2)) else $error("width wrong");
    AST_MODE: assert property ($stable({rom_enabled_pin, mode_width16_pin})[*5]
        ##0 !rom_enabled_pin |-> cfg.space_width16[0] == mode_width16_pin)
        else $error("space 0 width ignores mode pin");
    AST_IDLE: assert property (w2 && pstrb[1]
        |-> ##2 cfg.space_idle_count == $past(pwdata[15:8], 2)) else $error("idle wrong");
    AST_B2B: assert property (w2 && pstrb[0]
        |-> ##2 cfg.space_backtoback_idle == $past(pwdata[7:4], 2)) else $error("b2b wrong");
    AST_STRETCH: assert property (w2 && pstrb[0]
        |-> ##2 cfg.space_select_stretch == $past(pwdata[3:0], 2)) else $error("stretch wrong");
    AST_RESV: assert property (pready
        |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0000_0000))
        else $error("reserved read data");
endmodule : bus_space_config_checker
bind bus_space_config bus_space_config_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .rom_enabled_pin(rom_enabled_pin), .mode_width16_pin(mode_width16_pin));
`default_nettype wire

// ==== sim/mode_strap_model.sv ====
// Model of the board straps that set the operating mode.
// Pins move on the falling edge, out of step with the block's sampling.
`timescale 1ns/1ps
`default_nettype none
module mode_strap_model (
    input wire logic clk,
    input wire logic rom_on,
    input wire logic wide,
    output logic rom_enabled_pin,
    output logic mode_width16_pin
);
    // The pins are unknown until the first falling edge, which lies inside reset.
    always @(negedge clk) begin
        rom_enabled_pin <= rom_on;
        mode_width16_pin <= wide;
    end
endmodule : mode_strap_model
`default_nettype wire

// ==== sim/external_bus_space_config_tb.sv ====
// Self-checking bench for the bus space configuration block.
// Drives APB and the mode straps and keeps its own copy of the registers.
`timescale 1ns/1ps
`default_nettype none
module external_bus_space_config_tb
    import bus_space_pkg::*;
();
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic rom_on = 1'b1, wide = 1'b1, pready, pslverr, rom_pin, wide_pin;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] m1, m2, mc;
    logic [11:0] addrs [5] = '{12'h000, 12'h008, 12'h480, 12'h004, 12'h482};
    bus_space_cfg_t cfg;
    int bad_count = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    bus_space_config #(.ADDR_WIDTH(12)) i_bus_space_config (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_enabled_pin(rom_pin),
        .mode_width16_pin(wide_pin), .cfg(cfg));
    mode_strap_model i_mode_strap_model (.clk(clk), .rom_on(rom_on), .wide(wide),
        .rom_enabled_pin(rom_pin), .mode_width16_pin(wide_pin));
    // The settings carrier packs exactly the cache, first and second register fields in order.
    function automatic logic [31:0] exp_cfg();
        return 32'({mc[4:0], m1[8], m1[3:1], rom_on ? m1[0] : wide, m2});
    endfunction : exp_cfg
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // Leaves psel up so that the next transfer may follow with no idle cycle.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
    endtask : apb
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] rd;
        logic err, bad;
        logic [15:0] lm;
        bad = !(a inside {12'h000, 12'h008, 12'h480});
        lm = {{8{s[1]}}, {8{s[0]}}} & {16{wr}};
        if (wr) begin
            apb(1'b1, a, d, s, rd, err);
            check("write error", 32'(err), 32'(bad));
        end
        if (a == 12'h000) m1 = (m1 & ~lm) | (d[15:0] & lm & MASK_BUS_CONTROL_ONE);
        if (a == 12'h008) m2 = (m2 & ~lm) | (d[15:0] & lm & MASK_BUS_CONTROL_TWO);
        if (a == 12'h480) mc = (mc & ~lm) | (d[15:0] & lm & MASK_SPACE_CACHE_ENABLE);
        apb(1'b0, a, $urandom, 4'h0, rd, err);
        check("read error", 32'(err), 32'(bad));
        lm = bad ? 16'h0000 : a == 12'h000 ? m1 : a == 12'h008 ? m2 : mc;
        check("read data", rd, {16'h0000, lm});
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (4) @(posedge clk);
        check("cfg", 32'(cfg), exp_cfg());
    endtask : xfer
    task automatic do_reset(input int n);
        int i;
        rst <= 1'b1;
        m1 = RST_BUS_CONTROL_ONE;
        m2 = RST_BUS_CONTROL_TWO;
        mc = RST_SPACE_CACHE_ENABLE;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 3; i++) xfer(1'b0, addrs[i], 32'h0000_0000, 4'h0);
    endtask : do_reset
    initial begin
        int i;
        void'($urandom(85740));
        do_reset(12);
        for (i = 0; i < 60; i++) begin
            rom_on <= 1'($urandom);
            wide <= 1'($urandom);
            xfer(1'b1, addrs[$urandom_range(4, 0)], i < 2 ? {32{i[0]}} : $urandom,
                i < 2 ? 4'hf : 4'($urandom));
        end
        do_reset(2);
        wrap_up();
    end
endmodule : external_bus_space_config_tb
`default_nettype wire
